// file: adc_ctrl_defs.vh
// constants for the converter conversion control block
`ifndef ADC_CTRL_DEFS_VH
`define ADC_CTRL_DEFS_VH
`define BUS_CLK_HZ 100000000
`define CONV_CLK_MAX_HZ 2000000
// divide so the conversion clock never exceeds its maximum
`define PRESCALE_DIV ((`BUS_CLK_HZ + `CONV_CLK_MAX_HZ - 1) / `CONV_CLK_MAX_HZ)
`define PRESCALE_HALF (`PRESCALE_DIV / 2)
`define SAMPLE_CYCLES 14
`define SAR_BITS 10
`define CHAN_REFH 4'h8
`define CHAN_REFL 4'h9
`define ST_OFF 3'h0
`define ST_IDLE 3'h1
`define ST_SAMPLE 3'h2
`define ST_SAR 3'h3
`define ST_DONE 3'h4
`endif

// file: adc_ctrl.v
// conversion sequencing, power handling and result register for an eight-channel sar converter
`include "adc_ctrl_defs.vh"

module adc_ctrl (
   input wire REF_CLK,
   input wire ARST_N,
   input wire STOP_MODE,
   input wire POWER_UP_BIT,
   input wire SC_WRITE,
   input wire CTRL_WRITE,
   input wire PE_WRITE,
   input wire [3:0] CHANNEL_SEL,
   input wire CONTINUOUS,
   input wire COMPARE_IN,
   output reg ANALOG_ON,
   output reg CONV_CLK_EN,
   output reg SH_CLK_EN,
   output reg SAMPLING,
   output reg SAR_ACTIVE,
   output reg REF_SELECT,
   output reg [2:0] MUX_SEL,
   output reg [9:0] SAR_TRIAL,
   output reg [9:0] RESULT,
   output reg CONV_DONE
);

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers: stop and compare come from outside the clock domain
   wire stop_s2_r;
   wire cmp_s2_r;

   sync2 u_stop_sync (
      .clk(REF_CLK),
      .arst_n(ARST_N),
      .d_in(STOP_MODE),
      .q_r(stop_s2_r)
   );

   // comparator settles within a few cycles, far inside one tick period
   sync2 u_cmp_sync (
      .clk(REF_CLK),
      .arst_n(ARST_N),
      .d_in(COMPARE_IN),
      .q_r(cmp_s2_r)
   );

   // active only with power-up set and outside stop; the bit itself lives outside
   wire active = POWER_UP_BIT & ~stop_s2_r;

   ////////////////////////////////////////////////////////////////////////
   // prescaler: one tick per conversion clock period, halted when gated
   reg [6:0] pre_cnt_r;
   reg [6:0] pre_cnt_nxt;
   reg tick_r;
   always @* begin
      pre_cnt_nxt = pre_cnt_r + 7'h01;
      if (!active || pre_cnt_r == (`PRESCALE_DIV - 1))
         pre_cnt_nxt = 7'h00;
   end
   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pre_cnt_r <= 7'h00;
      end else begin
         pre_cnt_r <= pre_cnt_nxt;
      end
   end

   // held low while gated, so no phase advances in power-down
   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         tick_r <= 1'b0;
      end else begin
         tick_r <= active && (pre_cnt_r == (`PRESCALE_DIV - 1));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // mode control, sample-and-hold and sar sequencing
   reg [2:0] state_r, state_nxt;
   reg [3:0] samp_cnt_r, samp_cnt_nxt;
   reg [3:0] bit_r, bit_nxt;
   reg [9:0] sar_r, sar_nxt;
   reg [9:0] result_r, result_nxt;
   reg [3:0] chan_r, chan_nxt;
   reg done_nxt;
   wire is_ref = (CHANNEL_SEL == `CHAN_REFH) || (CHANNEL_SEL == `CHAN_REFL);

   always @* begin
      state_nxt = state_r;
      samp_cnt_nxt = samp_cnt_r;
      bit_nxt = bit_r;
      sar_nxt = sar_r;
      result_nxt = result_r;
      chan_nxt = chan_r;
      done_nxt = 1'b0;
      case (state_r)
         `ST_OFF: begin
            // no conversion resumes by itself on reactivation
            if (active)
               state_nxt = `ST_IDLE;
         end
         `ST_IDLE: begin
            if (SC_WRITE) begin
               chan_nxt = CHANNEL_SEL;
               samp_cnt_nxt = 4'h0;
               bit_nxt = 4'h9;
               sar_nxt = 10'h200;
               // references skip the sample phase
               state_nxt = is_ref ? `ST_SAR : `ST_SAMPLE;
            end
         end
         `ST_SAMPLE: begin
            if (tick_r) begin
               if (samp_cnt_r == (`SAMPLE_CYCLES - 1))
                  state_nxt = `ST_SAR;
               else
                  samp_cnt_nxt = samp_cnt_r + 4'h1;
            end
         end
         `ST_SAR: begin
            if (tick_r) begin
               if (chan_r == `CHAN_REFH)
                  sar_nxt[bit_r] = 1'b1;
               else if (chan_r == `CHAN_REFL)
                  sar_nxt[bit_r] = 1'b0;
               else
                  sar_nxt[bit_r] = cmp_s2_r;
               if (bit_r != 4'h0)
                  sar_nxt[bit_r - 4'h1] = 1'b1;
               if (bit_r == 4'h0)
                  state_nxt = `ST_DONE;
               else
                  bit_nxt = bit_r - 4'h1;
            end
         end
         `ST_DONE: begin
            // sar write port of the result register
            result_nxt = sar_r;
            done_nxt = 1'b1;
            if (CONTINUOUS) begin
               samp_cnt_nxt = 4'h0;
               bit_nxt = 4'h9;
               sar_nxt = 10'h200;
               state_nxt = (chan_r == `CHAN_REFH || chan_r == `CHAN_REFL) ? `ST_SAR : `ST_SAMPLE;
            end else
               state_nxt = `ST_IDLE;
         end
         default: state_nxt = `ST_OFF;
      endcase
      // status-and-control write restarts a running conversion
      if (state_r != `ST_OFF && state_r != `ST_IDLE && SC_WRITE) begin
         chan_nxt = CHANNEL_SEL;
         samp_cnt_nxt = 4'h0;
         bit_nxt = 4'h9;
         sar_nxt = 10'h200;
         done_nxt = 1'b0;
         result_nxt = result_r;
         state_nxt = is_ref ? `ST_SAR : `ST_SAMPLE;
      end else if (state_r != `ST_OFF && (CTRL_WRITE || PE_WRITE)) begin
         state_nxt = `ST_IDLE;
         done_nxt = 1'b0;
         result_nxt = result_r;
      end
      // stop or power-down wins over everything
      if (!active) begin
         state_nxt = `ST_OFF;
         done_nxt = 1'b0;
         result_nxt = result_r;
      end
   end

   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_r <= `ST_OFF;
      end else begin
         state_r <= state_nxt;
      end
   end

   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         samp_cnt_r <= 4'h0;
      end else begin
         samp_cnt_r <= samp_cnt_nxt;
      end
   end

   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         bit_r <= 4'h9;
      end else begin
         bit_r <= bit_nxt;
      end
   end

   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         sar_r <= 10'h000;
      end else begin
         sar_r <= sar_nxt;
      end
   end

   // kept through stop and power-down so software still reads it
   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         result_r <= 10'h000;
      end else begin
         result_r <= result_nxt;
      end
   end

   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         chan_r <= 4'h0;
      end else begin
         chan_r <= chan_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registered outputs; result is the independent bus read port
   // built from next-state values so each output lines up with its state
   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ANALOG_ON <= 1'b0;
      end else begin
         ANALOG_ON <= (state_nxt != `ST_OFF);
      end
   end

   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         CONV_CLK_EN <= 1'b0;
      end else begin
         CONV_CLK_EN <= (state_nxt != `ST_OFF);
      end
   end

   // one-hot phase: one held sample only
   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         SH_CLK_EN <= 1'b0;
      end else begin
         SH_CLK_EN <= (state_nxt == `ST_SAMPLE);
      end
   end

   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         SAMPLING <= 1'b0;
      end else begin
         SAMPLING <= (state_nxt == `ST_SAMPLE);
      end
   end

   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         SAR_ACTIVE <= 1'b0;
      end else begin
         SAR_ACTIVE <= (state_nxt == `ST_SAR);
      end
   end

   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         REF_SELECT <= 1'b0;
      end else begin
         REF_SELECT <= (chan_nxt == `CHAN_REFH) || (chan_nxt == `CHAN_REFL);
      end
   end

   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         MUX_SEL <= 3'h0;
      end else begin
         MUX_SEL <= chan_nxt[2:0];
      end
   end

   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         SAR_TRIAL <= 10'h000;
      end else begin
         SAR_TRIAL <= sar_nxt;
      end
   end

   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         RESULT <= 10'h000;
      end else begin
         RESULT <= result_nxt;
      end
   end

   always @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         CONV_DONE <= 1'b0;
      end else begin
         CONV_DONE <= done_nxt;
      end
   end

endmodule // adc_ctrl

////////////////////////////////////////////////////////////////////////
// two-stage synchroniser for an input asynchronous to the clock
module sync2 (
   input wire clk,
   input wire arst_n,
   input wire d_in,
   output reg q_r
);

   reg meta_r;

   // only the second stage is read outside, so metastability stays here
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_r <= 1'b0;
         q_r <= 1'b0;
      end else begin
         meta_r <= d_in;
         q_r <= meta_r;
      end
   end

endmodule // sync2

// file: adc_ctrl_assertions.sv
// port-level checks of the conversion control block
module adc_ctrl_assertions (
   input wire REF_CLK,
   input wire ARST_N,
   input wire STOP_MODE,
   input wire POWER_UP_BIT,
   input wire SC_WRITE,
   input wire CTRL_WRITE,
   input wire PE_WRITE,
   input wire ANALOG_ON,
   input wire CONV_CLK_EN,
   input wire SH_CLK_EN,
   input wire SAMPLING,
   input wire SAR_ACTIVE,
   input wire CONV_DONE,
   input wire [9:0] RESULT
);
   timeunit 1ns; timeprecision 1ns;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!ARST_N);
   logic [9:0] samp_cnt_r;
   // a restart while sampling opens a fresh window
   always @(posedge REF_CLK or negedge ARST_N)
      if (!ARST_N) samp_cnt_r <= 10'h000;
      else samp_cnt_r <= (SAMPLING && !SC_WRITE) ? samp_cnt_r + 10'h001 : 10'h000;
   sequence s_quiet; !SAMPLING && !SAR_ACTIVE; endsequence
   sequence s_to_sar; !SAMPLING && SAR_ACTIVE; endsequence
   sequence s_done; ##[0:1] CONV_DONE; endsequence
   a_no_overlap: assert property (!(SAMPLING && SAR_ACTIVE))
      else $error("phases overlap");
   a_sh_gate: assert property (SH_CLK_EN == SAMPLING)
      else $error("hold clock not gated");
   a_down_off: assert property (!POWER_UP_BIT [*3] |-> (!CONV_CLK_EN && !ANALOG_ON) ##0 s_quiet)
      else $error("not off in power-down");
   a_stop_off: assert property (STOP_MODE [*5] |-> !ANALOG_ON ##0 s_quiet)
      else $error("not off in stop");
   a_sc_start: assert property (SC_WRITE && ANALOG_ON && POWER_UP_BIT && !STOP_MODE |=> SAMPLING || SAR_ACTIVE)
      else $error("write did not start");
   a_abort_idle: assert property ((CTRL_WRITE || PE_WRITE) && !SC_WRITE |=> s_quiet)
      else $error("abort left a phase on");
   a_result_hold: assert property (RESULT != $past(RESULT) |-> CONV_DONE)
      else $error("result moved without done");
   a_hand_over: assert property ($fell(SAMPLING) && ANALOG_ON && POWER_UP_BIT
      && !$past(SC_WRITE || CTRL_WRITE || PE_WRITE) |-> s_to_sar)
      else $error("no sar after sample");
   a_sample_len: assert property ($fell(SAMPLING) && SAR_ACTIVE |-> samp_cnt_r inside {[650:701]})
      else $error("sample window length");
   a_done_after: assert property ($fell(SAR_ACTIVE) && !SAMPLING && ANALOG_ON && POWER_UP_BIT
      && !$past(SC_WRITE || CTRL_WRITE || PE_WRITE) |-> s_done)
      else $error("no done after sar");
endmodule // adc_ctrl_assertions

// file: analog_src.sv
// comparator and analog source on the far side of the sar loop
module analog_src (
   input wire REF_CLK,
   input wire ANALOG_ON,
   input wire REF_SELECT,
   input wire ref_hi,
   input wire [9:0] level,
   input wire [9:0] SAR_TRIAL,
   output logic COMPARE_IN
);
   timeunit 1ns; timeprecision 1ns;
   initial COMPARE_IN = 1'b0;
   always @(posedge REF_CLK) begin
      if (!ANALOG_ON) COMPARE_IN <= ~COMPARE_IN; // analog off gives no level
      else if (REF_SELECT) COMPARE_IN <= ref_hi;
      else COMPARE_IN <= (level >= SAR_TRIAL); // half lsb up, so code equals level
   end
endmodule // analog_src

// file: tb_top.sv
// self-checking bench for the conversion control block
module tb_top;
   timeunit 1ns; timeprecision 1ns;
   logic REF_CLK = 0, ARST_N = 0, STOP_MODE = 0, POWER_UP_BIT = 0, SC_WRITE = 0;
   logic CTRL_WRITE = 0, PE_WRITE = 0, CONTINUOUS = 0, ref_hi = 0, got;
   logic [3:0] CHANNEL_SEL = 4'h0;
   logic [9:0] level = 10'h000, want, old;
   logic [31:0] seed = 32'h00009AAA, r;
   wire COMPARE_IN, ANALOG_ON, CONV_CLK_EN, SH_CLK_EN, SAMPLING, SAR_ACTIVE, REF_SELECT, CONV_DONE;
   wire [2:0] MUX_SEL;
   wire [9:0] SAR_TRIAL, RESULT;
   int fail_count = 0, checks_done = 0, cyc = 0;
   always #5 REF_CLK = ~REF_CLK;
   adc_ctrl u_adc_ctrl (.*);
   analog_src u_analog_src (.*);
   task automatic finish_test;
      if (fail_count == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [9:0] g, input logic [9:0] e);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   function automatic logic [31:0] xs;
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [9:0] exp_res(input logic [3:0] ch, input logic [9:0] lv);
      if (ch == 4'h8) return 10'h3FF;
      return (ch == 4'h9) ? 10'h000 : lv;
   endfunction
   task automatic start(input logic [3:0] ch);
      r = xs();
      @(posedge REF_CLK);
      level <= r[9:0];
      CHANNEL_SEL <= ch;
      ref_hi <= (ch == 4'h8);
      SC_WRITE <= 1'b1;
      want = exp_res(ch, r[9:0]);
      @(posedge REF_CLK);
      SC_WRITE <= 1'b0;
      #1 if (ch < 4'h8 && POWER_UP_BIT) chk(MUX_SEL, ch);
      chk(REF_SELECT, POWER_UP_BIT && ch > 4'h7);
      chk(SAR_TRIAL, POWER_UP_BIT ? 10'h200 : 10'h000);
      chk({SAMPLING, SH_CLK_EN, SAR_ACTIVE}, !POWER_UP_BIT ? 3'b000 : (ch > 4'h7) ? 3'b001 : 3'b110);
   endtask
   task automatic wdone(input int n);
      got = 0;
      for (int i = 0; i < n && got !== 1'b1; i++) begin
         @(posedge REF_CLK);
         #1 got = CONV_DONE;
      end
   endtask
   // a hung handshake must still reach the verdict
   always @(posedge REF_CLK) begin
      cyc++;
      if (cyc == 40000) begin
         fail_count++;
         finish_test();
      end
   end
   initial begin
      repeat (10) @(posedge REF_CLK);
      ARST_N <= 1'b1;
      repeat (2) @(posedge REF_CLK);
      #1 chk(ANALOG_ON, 0);
      chk(RESULT, 0);
      start(4'h1);
      wdone(1500);
      chk({got, CONV_CLK_EN, ANALOG_ON}, 0);
      @(posedge REF_CLK) POWER_UP_BIT <= 1'b1;
      repeat (3) @(posedge REF_CLK);
      // both references first, then random inputs
      for (int i = 0; i < 6; i++) begin
         r = xs();
         start(i < 2 ? {3'h4, i[0]} : {1'b0, r[2:0]});
         wdone(1500);
         chk(got, 1);
         chk(RESULT, want);
      end
      start(4'h3);
      repeat (200) @(posedge REF_CLK);
      start(4'h5);
      wdone(1500);
      chk(got, 1);
      chk(RESULT, want);
      // continuous mode restarts by itself until CONTINUOUS is cleared
      @(posedge REF_CLK) CONTINUOUS <= 1'b1;
      start(4'h6);
      for (int j = 0; j < 2; j++) begin
         wdone(1500);
         chk(got, 1);
         chk(RESULT, want);
      end
      @(posedge REF_CLK) CONTINUOUS <= 1'b0;
      wdone(1500);
      chk(got, 1);
      wdone(1500);
      chk(got, 0);
      for (int k = 0; k < 4; k++) begin
         old = RESULT;
         start({2'b00, k[1:0]});
         repeat (250 + 250 * k) @(posedge REF_CLK);
         CTRL_WRITE <= (k == 0);
         PE_WRITE <= (k == 1);
         POWER_UP_BIT <= (k != 2);
         STOP_MODE <= (k == 3);
         @(posedge REF_CLK);
         CTRL_WRITE <= 1'b0;
         PE_WRITE <= 1'b0;
         wdone(1500);
         chk(got, 0);
         chk(RESULT, old);
         @(posedge REF_CLK);
         POWER_UP_BIT <= 1'b1;
         STOP_MODE <= 1'b0;
         wdone(1500);
         chk(got, 0);
         chk(RESULT, old);
         chk(ANALOG_ON, 1);
      end
      finish_test();
   end
endmodule // tb_top
bind adc_ctrl adc_ctrl_assertions u_adc_ctrl_assertions (.*);
